// ===== core/data_space_consts.svh
// Purpose: Address constants for the data space decoder.
// Assumes: 16-bit external data addresses, 7-bit internal RAM addresses.
// Notes: Windows are inclusive start and stop addresses.
`ifndef DATA_SPACE_CONSTS_SVH
`define DATA_SPACE_CONSTS_SVH
`define XRAM_LO 16'h8000
`define XRAM_HI 16'h83FF
`define SCU_LO 16'h9000
`define SCU_HI 16'h9002
`define CAL_LO 16'h9100
`define CAL_HI 16'h9133
`define WDU_LO 16'h9180
`define WDU_HI 16'h9181
`define LCD_LO 16'h9200
`define LCD_HI 16'h9220
`define MSP_LO 16'h9300
`define MSP_HI 16'h9338
`define SPI_LO 16'h9400
`define SPI_HI 16'h9403
`define MIO_LO 16'h9500
`define MIO_HI 16'h951F
`define MIO_SMALL_HI 16'h951A
`define PROG_HI 16'h5FFF
`define BANK_TOP 8'h1F
`define BIT_BASE 8'h20
`define DIRECT_TOP 8'h7F
`define SPECIAL_REG_BASE 8'h80
`endif

// ===== core/data_space_pkg.sv
// Purpose: Types for the data space decoder.
// Assumes: Nothing beyond the constants header.
// Notes: Target codes order the select vector.
package data_space_pkg;
    typedef enum logic [3:0] {
        TGT_NONE, TGT_XRAM, TGT_SCU, TGT_CAL, TGT_WDU, TGT_LCD, TGT_MSP, TGT_SPI, TGT_MIO
    } target_t;
    typedef enum logic [1:0] {
        IMODE_DIRECT, IMODE_REGISTER, IMODE_INDIRECT
    } imode_t;
endpackage

// ===== core/mcu_data_space_decoder.sv
// Purpose: Decodes core external data and internal RAM accesses.
// Assumes: Core requests are synchronous to MCLK and one cycle long.
// Notes: All outputs are registered, so selects follow a request by one cycle and read data by two.
// Contract
// R1 - 8000h-83FFh maps to external data RAM
// R2 - Control, calendar and watchdog windows routed
// R3 - LCD, metering, SPI, I/O windows routed
// R4 - Larger-variant I/O addresses ignored on small
// R5 - 128 byte RAM, all directly addressable
// R6 - Four banks of eight registers, status-word select
// R7 - Bit n selects bit n mod 8
// R8 - 30h-7Fh only via direct address
// R9 - Only registers 0 and 1 are pointers
// R10 - Program reads limited to 24 kB region
// R11 - Indirect external access takes port two high
// R12 - Direct upper range selects function registers
// R13 - Unmapped reads zero, writes ignored
// R14 - One select, one cycle, data aligned
`include "data_space_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module mcu_data_space_decoder #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic SYNC_RST,
    input wire logic XREQ,
    input wire logic XWRITE,
    input wire logic XUSE_RI,
    input wire logic [15:0] XADDR,
    input wire logic [7:0] RI_VALUE,
    input wire logic [7:0] PORT_TWO_REGISTER,
    input wire logic [7:0] XWDATA,
    input wire logic [7:0] XRDATA_IN,
    input wire logic PREQ,
    input wire logic [15:0] PADDR,
    input wire logic IREQ,
    input wire logic [1:0] IMODE,
    input wire logic [7:0] IOPERAND,
    input wire logic [1:0] BANK_SEL,
    input wire logic IBIT,
    input wire logic [6:0] IBITADDR,
    output logic [8:0] XSEL,
    output logic [15:0] XADDR_OUT,
    output logic [7:0] XWDATA_OUT,
    output logic XWR_STB,
    output logic [7:0] XRDATA,
    output logic PSEL,
    output logic [15:0] PADDR_OUT,
    output logic ISEL_RAM,
    output logic ISEL_SPECIAL_FUNCTION_REGISTER,
    output logic [6:0] IADDR_OUT,
    output logic [2:0] IBIT_POS,
    output logic IBIT_OP,
    output logic IERR
);
    function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction

    logic [15:0] xa;
    data_space_pkg::target_t tgt;
    logic [8:0] xsel_r, xsel_nxt;
    logic [15:0] xaddr_r, xaddr_nxt;
    logic [7:0] xwdata_r, xwdata_nxt;
    logic xwr_r, xwr_nxt;
    logic [7:0] xrdata_r, xrdata_nxt;
    logic psel_r, psel_nxt;
    logic [15:0] paddr_r, paddr_nxt;
    logic iram_r, iram_nxt, isfr_r, isfr_nxt, ibop_r, ibop_nxt, ierr_r, ierr_nxt;
    logic [6:0] iaddr_r, iaddr_nxt;
    logic [2:0] ibpos_r, ibpos_nxt;

    always_comb begin
        xa = XUSE_RI ? {PORT_TWO_REGISTER, RI_VALUE} : XADDR; // R11
        tgt = data_space_pkg::TGT_NONE;
        if (in_win(xa, `XRAM_LO, `XRAM_HI)) begin
            tgt = data_space_pkg::TGT_XRAM; // R1
        end else if (in_win(xa, `SCU_LO, `SCU_HI)) begin
            tgt = data_space_pkg::TGT_SCU; // R2
        end else if (in_win(xa, `CAL_LO, `CAL_HI)) begin
            tgt = data_space_pkg::TGT_CAL; // R2
        end else if (in_win(xa, `WDU_LO, `WDU_HI)) begin
            tgt = data_space_pkg::TGT_WDU; // R2
        end else if (in_win(xa, `LCD_LO, `LCD_HI)) begin
            tgt = data_space_pkg::TGT_LCD; // R3
        end else if (in_win(xa, `MSP_LO, `MSP_HI)) begin
            tgt = data_space_pkg::TGT_MSP; // R3
        end else if (in_win(xa, `SPI_LO, `SPI_HI)) begin
            tgt = data_space_pkg::TGT_SPI; // R3
        end else if (in_win(xa, `MIO_LO, LARGE_VARIANT ? `MIO_HI : `MIO_SMALL_HI)) begin
            tgt = data_space_pkg::TGT_MIO; // R3 R4
        end
        xsel_nxt = '0;
        xaddr_nxt = xaddr_r;
        xwdata_nxt = xwdata_r;
        xwr_nxt = 1'b0;
        xrdata_nxt = xrdata_r;
        if (XREQ) begin
            xaddr_nxt = xa;
            xwdata_nxt = XWDATA;
            xrdata_nxt = 8'h00; // R13
            if (tgt != data_space_pkg::TGT_NONE) begin
                xsel_nxt[4'(tgt) - 4'h1] = 1'b1; // R14
                xwr_nxt = XWRITE; // R14
            end
        end else if (xsel_r != 9'h000 && !xwr_r) begin
            // Read data returns from the selected target in the cycle after the select.
            xrdata_nxt = XRDATA_IN;
        end
        if (SYNC_RST) begin
            xsel_nxt = '0; // R14
            xwr_nxt = 1'b0;
        end
    end

    always_comb begin
        psel_nxt = PREQ && (PADDR <= `PROG_HI); // R10
        paddr_nxt = PREQ ? PADDR : paddr_r;
        if (SYNC_RST) begin
            psel_nxt = 1'b0; // R14
        end
    end

    always_comb begin
        iram_nxt = 1'b0;
        isfr_nxt = 1'b0;
        ibop_nxt = 1'b0;
        ierr_nxt = 1'b0;
        iaddr_nxt = iaddr_r;
        ibpos_nxt = 3'h0;
        if (IREQ) begin
            if (IBIT) begin
                iram_nxt = 1'b1;
                ibop_nxt = 1'b1;
                iaddr_nxt = 7'(`BIT_BASE) + {3'h0, IBITADDR[6:3]}; // R7
                ibpos_nxt = IBITADDR[2:0]; // R7
            end else begin
                case (data_space_pkg::imode_t'(IMODE))
                    data_space_pkg::IMODE_REGISTER: begin
                        iram_nxt = 1'b1;
                        iaddr_nxt = {2'h0, BANK_SEL, IOPERAND[2:0]}; // R6
                    end
                    data_space_pkg::IMODE_INDIRECT: begin
                        if (IOPERAND[2:1] == 2'h0) begin
                            iram_nxt = 1'b1;
                            iaddr_nxt = {2'h0, BANK_SEL, 2'h0, IOPERAND[0]}; // R9
                        end else begin
                            ierr_nxt = 1'b1; // R9
                        end
                    end
                    data_space_pkg::IMODE_DIRECT: begin
                        if (IOPERAND >= `SPECIAL_REG_BASE) begin
                            isfr_nxt = 1'b1; // R12
                        end else begin
                            iram_nxt = 1'b1; // R5 R8
                        end
                        iaddr_nxt = IOPERAND[6:0]; // R5
                    end
                    default: begin
                        ierr_nxt = 1'b1;
                    end
                endcase
            end
        end
        if (SYNC_RST) begin
            iram_nxt = 1'b0; // R14
            isfr_nxt = 1'b0;
            ibop_nxt = 1'b0;
            ierr_nxt = 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            xsel_r <= '0;
            xaddr_r <= 16'h0000;
            xwdata_r <= 8'h00;
            xwr_r <= 1'b0;
            xrdata_r <= 8'h00;
        end else begin
            xsel_r <= xsel_nxt;
            xaddr_r <= xaddr_nxt;
            xwdata_r <= xwdata_nxt;
            xwr_r <= xwr_nxt;
            xrdata_r <= xrdata_nxt;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            psel_r <= 1'b0;
            paddr_r <= 16'h0000;
        end else begin
            psel_r <= psel_nxt;
            paddr_r <= paddr_nxt;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            iram_r <= 1'b0;
            isfr_r <= 1'b0;
            ibop_r <= 1'b0;
            ierr_r <= 1'b0;
            iaddr_r <= 7'h00;
            ibpos_r <= 3'h0;
        end else begin
            iram_r <= iram_nxt;
            isfr_r <= isfr_nxt;
            ibop_r <= ibop_nxt;
            ierr_r <= ierr_nxt;
            iaddr_r <= iaddr_nxt;
            ibpos_r <= ibpos_nxt;
        end
    end

    assign XSEL = xsel_r;
    assign XADDR_OUT = xaddr_r;
    assign XWDATA_OUT = xwdata_r;
    assign XWR_STB = xwr_r;
    assign XRDATA = xrdata_r;
    assign PSEL = psel_r;
    assign PADDR_OUT = paddr_r;
    assign ISEL_RAM = iram_r;
    assign ISEL_SPECIAL_FUNCTION_REGISTER = isfr_r;
    assign IADDR_OUT = iaddr_r;
    assign IBIT_POS = ibpos_r;
    assign IBIT_OP = ibop_r;
    assign IERR = ierr_r;
endmodule
`default_nettype wire

// ===== verif/xdata_target_model.sv
// Purpose: Far-side targets answering external data reads.
// Assumes: A target answers while its select is high.
// Notes: Unselected, the bus shows the inverse of its last value.
`timescale 1ns/1ns
`default_nettype none
module xdata_target_model (
    input wire logic MCLK,
    input wire logic [8:0] XSEL,
    input wire logic [15:0] XADDR_OUT,
    output logic [7:0] XRDATA_IN
);
    logic [7:0] last_r = 8'h00;
    assign XRDATA_IN = |XSEL ? XADDR_OUT[7:0] ^ 8'hA5 : ~last_r;
    always @(posedge MCLK) last_r <= XRDATA_IN;
endmodule
`default_nettype wire

// ===== verif/mcu_data_space_decoder_monitor.sv
// Purpose: Port checker for the data space decoder.
// Assumes: Bound by port name.
// Notes: Single clock domain.
`timescale 1ns/1ns
`default_nettype none
module mcu_data_space_decoder_monitor (
    input wire logic MCLK, RST_N, SYNC_RST, XREQ, XWRITE, XUSE_RI, PREQ, IREQ, IBIT, XWR_STB, PSEL, IBIT_OP,
    input wire logic ISEL_RAM, ISEL_SPECIAL_FUNCTION_REGISTER,
    input wire logic [15:0] XADDR, PADDR, XADDR_OUT,
    input wire logic [8:0] XSEL,
    input wire logic [7:0] RI_VALUE, PORT_TWO_REGISTER, IOPERAND, XRDATA,
    input wire logic [6:0] IBITADDR, IADDR_OUT,
    input wire logic [2:0] IBIT_POS,
    input wire logic [1:0] IMODE, BANK_SEL
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    logic go;
    assign go = XREQ && !SYNC_RST && !XUSE_RI;
    sequence quiet;
        XSEL == 9'h000 && !XWR_STB ##1 XRDATA == 8'h00;
    endsequence
    a_xram_map: assert property (go && XADDR[15:10] == 6'h20 |=> XSEL == 9'h001 && XWR_STB == $past(XWRITE))
        else $error("xram map");
    a_cal_route: assert property (go && XADDR >= 16'h9100 && XADDR <= 16'h9133 |=> XSEL == 9'h004)
        else $error("calendar map");
    a_unmapped_quiet: assert property (go && !XADDR[15] |=> quiet)
        else $error("unmapped access");
    a_one_select: assert property (|XSEL |-> $onehot(XSEL) && $past(XREQ))
        else $error("select shape");
    a_ptr_high: assert property (XREQ && XUSE_RI && !SYNC_RST
        |=> XADDR_OUT == {$past(PORT_TWO_REGISTER), $past(RI_VALUE)}) else $error("pointer address");
    a_prog_limit: assert property (PREQ && !SYNC_RST |=> PSEL == ($past(PADDR) <= 16'h5FFF))
        else $error("program select");
    a_bit_map: assert property (IREQ && IBIT && !SYNC_RST |=> IBIT_OP
        && IADDR_OUT == 7'h20 + ($past(IBITADDR) >> 3) && IBIT_POS == 3'($past(IBITADDR))) else $error("bit map");
    a_bank_reg: assert property (IREQ && !IBIT && IMODE == 2'h1 && !SYNC_RST
        |=> IADDR_OUT == {2'h0, $past(BANK_SEL), 3'($past(IOPERAND))}) else $error("bank map");
    a_sync_quiet: assert property (SYNC_RST |=> XSEL == 9'h000 && !XWR_STB && !PSEL && !IBIT_OP)
        else $error("sync reset select");
    a_direct_split: assert property (IREQ && !IBIT && IMODE == 2'h0 && !SYNC_RST
        |=> ISEL_SPECIAL_FUNCTION_REGISTER == $past(IOPERAND[7]) && ISEL_RAM != $past(IOPERAND[7]))
        else $error("direct split");
endmodule
`default_nettype wire

// ===== verif/mcu_data_space_decoder_bench.sv
// Purpose: Self-checking bench for the data space decoder.
// Assumes: Large variant as dut, small variant beside it; writes use the pointer path.
// Notes: Each scenario task judges its own traffic.
`timescale 1ns/1ns
`default_nettype none
module mcu_data_space_decoder_bench;
    logic MCLK = 1'h0, RST_N = 1'h0, SYNC_RST = 1'h0, XREQ = 1'h0, XWRITE = 1'h0, XUSE_RI = 1'h0;
    logic PREQ = 1'h0, IREQ = 1'h0, IBIT = 1'h0, XWR_STB, PSEL, ISEL_RAM, IBIT_OP, IERR;
    logic ISEL_SPECIAL_FUNCTION_REGISTER;
    logic [15:0] XADDR = '0, PADDR = '0, XADDR_OUT, PADDR_OUT;
    logic [8:0] XSEL, xsel_small;
    logic [7:0] RI_VALUE = '0, PORT_TWO_REGISTER = '0, XWDATA = '0, IOPERAND = '0, XRDATA_IN, XWDATA_OUT, XRDATA;
    logic [6:0] IBITADDR = '0, IADDR_OUT;
    logic [2:0] IBIT_POS;
    logic [1:0] IMODE = '0, BANK_SEL = '0;
    int bad_count = 0, total_checks = 0;
    localparam logic [15:0] AD [13] = '{16'h8000, 16'h83FF, 16'h8400, 16'h9002, 16'h9133, 16'h9181, 16'h9338,
        16'h951F, 16'h7FFF, 16'h9003, 16'h9220, 16'h9400, 16'h951B};
    localparam logic [8:0] SL [13] = '{9'h001, 9'h001, 9'h000, 9'h002, 9'h004, 9'h008, 9'h020, 9'h080,
        9'h000, 9'h000, 9'h010, 9'h040, 9'h080};
    mcu_data_space_decoder dut (.*);
    mcu_data_space_decoder #(.LARGE_VARIANT(1'b0)) dut_small (.*, .XSEL(xsel_small), .XADDR_OUT(), .XWDATA_OUT(),
        .XWR_STB(), .XRDATA(), .PSEL(), .PADDR_OUT(), .ISEL_RAM(), .ISEL_SPECIAL_FUNCTION_REGISTER(), .IADDR_OUT(),
        .IBIT_POS(), .IBIT_OP(), .IERR());
    xdata_target_model far_side (.*);
    always #5 MCLK = ~MCLK;
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic xacc(input logic [15:0] a, input logic w, input logic [8:0] sel);
        @(posedge MCLK);
        XREQ <= 1'h1;
        XWRITE <= w;
        XUSE_RI <= w;
        XADDR <= w ? ~a : a;
        XWDATA <= a[15:8] ^ a[7:0];
        {PORT_TWO_REGISTER, RI_VALUE} <= a;
        @(posedge MCLK);
        XREQ <= 1'h0;
        #1 chk("xsel", XSEL, sel);
        chk("xsel_small", xsel_small, a >= 16'h951B && a <= 16'h951F ? 9'h000 : sel);
        chk("xstb", XWR_STB, w && |sel);
        chk("xaddr", XADDR_OUT, a);
        chk("xwdata", XWDATA_OUT, a[15:8] ^ a[7:0]);
        @(posedge MCLK);
        #1 chk("xrdata", XRDATA, w || !sel ? 8'h00 : a[7:0] ^ 8'hA5);
    endtask
    task automatic t_xmap();
        for (int i = 0; i < 13; i++) begin
            xacc(AD[i], 1'h0, SL[i]);
            xacc(AD[i], 1'h1, SL[i]);
        end
        $display("xmap done");
    endtask
    task automatic iacc(input logic b, input logic [1:0] m, input logic [7:0] op, input logic [9:0] e);
        @(posedge MCLK);
        IREQ <= 1'h1;
        PREQ <= 1'h1;
        PADDR <= 16'h5FF0 + 16'(op);
        IBIT <= b;
        IMODE <= m;
        IOPERAND <= op;
        IBITADDR <= op[6:0];
        BANK_SEL <= op[4:3];
        @(posedge MCLK);
        IREQ <= 1'h0;
        PREQ <= 1'h0;
        #1 chk("iram", {ISEL_RAM, ISEL_SPECIAL_FUNCTION_REGISTER, IERR, e[9] ? IADDR_OUT : 7'h00},
            e);
        chk("ibit", {IBIT_OP, IBIT_POS}, b ? {1'h1, op[2:0]} : 4'h0);
        chk("psel", PSEL, op < 8'h10);
        chk("paddr", PADDR_OUT, 16'h5FF0 + 16'(op));
    endtask
    task automatic t_iram();
        iacc(1'h1, 2'h0, 8'h0F, 10'h221);
        iacc(1'h1, 2'h0, 8'h7F, 10'h22F);
        iacc(1'h0, 2'h1, 8'h10, 10'h210);
        iacc(1'h0, 2'h0, 8'h30, 10'h230);
        iacc(1'h0, 2'h0, 8'h90, 10'h100);
        iacc(1'h0, 2'h2, 8'h02, 10'h080);
        iacc(1'h1, 2'h0, 8'h0B, 10'h221);
        iacc(1'h0, 2'h2, 8'h09, 10'h209);
        iacc(1'h0, 2'h3, 8'h05, 10'h080);
        $display("iram done");
    endtask
    task automatic t_reset();
        @(posedge MCLK);
        SYNC_RST <= 1'h1;
        XREQ <= 1'h1;
        XWRITE <= 1'h1;
        XUSE_RI <= 1'h0;
        XADDR <= 16'h8001;
        PREQ <= 1'h1;
        PADDR <= 16'h0001;
        IREQ <= 1'h1;
        IBIT <= 1'h1;
        @(posedge MCLK);
        {SYNC_RST, XREQ, PREQ, IREQ} <= 4'h0;
        #1 chk("sync", {XSEL, XWR_STB, PSEL, ISEL_RAM, IBIT_OP}, 16'h0000);
        $display("reset done");
    endtask
    initial begin
        repeat (2) @(posedge MCLK);
        RST_N <= 1'h1;
        t_xmap();
        t_iram();
        t_reset();
        finish_test();
    end
    initial begin
        #20000;
        bad_count++;
        finish_test();
    end
endmodule
bind mcu_data_space_decoder mcu_data_space_decoder_monitor mon (.*);
`default_nettype wire
